// ### src/ioc_consts.svh
`ifndef IOC_CONSTS_SVH
`define IOC_CONSTS_SVH

// Register byte addresses
`define IOC_OFF_CTRL     8'h00
`define IOC_OFF_STATUS   8'h04
`define IOC_OFF_FIFO     8'h0c
`define IOC_OFF_FIFO_ALT 8'h40

// Control register bit positions
`define IOC_B_TXRST   0
`define IOC_B_RXRST   1
`define IOC_B_LVLLD   2
`define IOC_B_LOOP    3
`define IOC_B_MASTER  4
`define IOC_B_FORCE   5
`define IOC_B_USEEXT  6
`define IOC_B_STCLR   7
`define IOC_B_EN_LO   8
`define IOC_B_EN_HI   11
`define IOC_B_RXSTART 12
`define IOC_B_TXSTART 13
`define IOC_B_STSTEN  14
`define IOC_B_LEDCTL  15
`define IOC_B_LEDON   16
`define IOC_B_SCLK    20
`define IOC_B_S2      21
`define IOC_B_SDATA   22
`define IOC_B_PLLEN   23

// Bits held by the control register; start bit and its enable are handled apart
`define IOC_CTRL_MASK  32'h00f1_9fff
`define IOC_CTRL_RESET 32'h0000_0000

// Status register bit positions
`define IOC_S_LAT_LO  8
`define IOC_S_LAT_HI  11
`define IOC_S_INTACT  13
`define IOC_S_SDATA   15

// Latch index inside the four-bit latch vector
`define IOC_L_DONE 0
`define IOC_L_OVR  1
`define IOC_L_AE   2
`define IOC_L_AF   3

// Default thresholds of the internal FIFO
`define IOC_AE_RESET 12'h010
`define IOC_AF_RESET 12'h7f0

// LED blink timing
`define IOC_CLK_NS      8
`define IOC_LED_HALF_NS 250000000

`endif

// ### src/ioc_pkg.sv
package ioc_pkg;

  // Flags of one FIFO as seen by a data direction
  typedef struct packed {
    logic empty;
    logic full;
    logic aempty;
    logic afull;
  } ioc_fifo_st_s;

  // Transmit word sequencer
  typedef enum logic [1:0] {
    TX_IDLE,
    TX_FETCH,
    TX_SEND
  } ioc_tx_e;

endpackage

// ### src/ioc_ram.sv
`timescale 1ns/1ps
`default_nettype none

// Simple dual-port storage with a registered read port
module ioc_ram #(
  parameter int W  = 32,
  parameter int AW = 11
) (
  // Clock
  input  wire logic          mclk,
  // Write port
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [W-1:0]  wdata,
  // Read port
  input  wire logic          rd_en,
  input  wire logic [AW-1:0] raddr,
  output logic      [W-1:0]  rdata_q
);

  logic [W-1:0] mem [0:(1<<AW)-1];

  // Write and registered read
  always_ff @(posedge mclk)
  begin
    if (wr_en)
      mem[waddr] <= wdata;
    if (rd_en)
      rdata_q <= mem[raddr];
  end

endmodule

`default_nettype wire

// ### src/ioc_base_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "ioc_consts.svh"

// Summary of operation
// - FIFO reset bit clears that direction's FIFO, sequencer and status latches.
// - Loop-back bit moves each host transmit word straight into the receive FIFO, except while receive reset is set.
// - Level-load steers FIFO data accesses to the threshold registers.
// - Master enable gates enabled latched conditions onto the host interrupt.
// - Force bit raises the interrupt when the master enable is set.
// - Use-external sends transmit to external FIFO, receive to internal; zero swaps.
// - Start-clear enable lets the done event clear the transmit start bit.
// - Done latch sets when the started transmitter, after sending a word, finds its FIFO empty.
// - Overrun latch sets when the receiver writes into a full FIFO.
// - Almost-empty latch sets when transmit level is at or below threshold.
// - Almost-full latch sets when receive level is at or above threshold.
// - Receive start enables byte capture packed into 32-bit receive words.
// - Transmit start lets the transmitter send whenever its FIFO holds data.
// - Transmit start changes on writes carrying the start/stop enable bit, or clears on done under start-clear.
// - LED follows LED-on under LED control, else blinks about twice a second.
// - PLL clock is always an output; PLL data is open drain, read via status.
// - PLL signals are driven only while the PLL enable bit is set.
module ioc_base_control #(
  parameter int AW           = 11,
  parameter int LED_HALF_CYC = `IOC_LED_HALF_NS / `IOC_CLK_NS
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  // Host local bus
  input  wire logic [7:0]  hb_addr,
  input  wire logic        hb_wr,
  input  wire logic        hb_rd,
  input  wire logic [31:0] hb_wdata,
  output logic      [31:0] hb_rdata,
  output logic             hb_rvalid,
  output logic             host_irq,
  // External FIFO
  output logic             xf_wr_en,
  output logic      [31:0] xf_wdata,
  output logic             xf_rd_en,
  input  wire logic [31:0] xf_rdata,
  input  wire logic        xf_empty,
  input  wire logic        xf_full,
  input  wire logic        xf_almost_empty,
  input  wire logic        xf_almost_full,
  output logic             xf_load,
  output logic             xf_rst,
  // Transmit word stream
  output logic      [31:0] tx_data,
  output logic             tx_valid,
  input  wire logic        tx_ready,
  // Receive byte stream
  input  wire logic [7:0]  rx_byte,
  input  wire logic        rx_byte_valid,
  // LED and PLL control pins
  output logic             user_led,
  output logic             pll_sclk,
  output logic             pll_s2,
  output logic             pll_sdata_o,
  output logic             pll_sdata_oe_n,
  input  wire logic        pll_sdata_i
);

  localparam int DEPTH = 1 << AW;

  // Select the flags of one of the two FIFOs for one direction
  function automatic ioc_pkg::ioc_fifo_st_s sel_st(input logic pick_ext,
                                                   input ioc_pkg::ioc_fifo_st_s ext_st,
                                                   input ioc_pkg::ioc_fifo_st_s int_st);
    sel_st = pick_ext ? ext_st : int_st;
  endfunction

  logic [31:0]           ctrl_q;
  logic                  tx_start_q;
  logic [3:0]            lat_q;
  logic                  irq_q;
  logic [AW-1:0]         wp_q;
  logic [AW-1:0]         rp_q;
  logic [AW:0]           cnt_q;
  logic [AW:0]           ae_thr_q;
  logic [AW:0]           af_thr_q;
  logic                  lvl_ptr_q;
  ioc_pkg::ioc_tx_e      tx_st_q;
  logic [31:0]           tx_data_q;
  logic                  tx_sent_q;
  logic [1:0]            rx_bcnt_q;
  logic [23:0]           rx_sh_q;
  logic [31:0]           rx_word_q;
  logic                  rx_wv_q;
  logic [2:0]            rd_sel_q;
  logic [31:0]           rdata_q;
  logic                  rvalid_q;
  logic [31:0]           led_cnt_q;
  logic                  led_blink_q;
  logic                  sd_s1_q;
  logic                  sd_s2_q;
  logic                  sd_s3_q;
  logic                  sd_in_q;
  logic [31:0]           int_rdata;
  ioc_pkg::ioc_fifo_st_s tx_st;
  ioc_pkg::ioc_fifo_st_s rx_st;

  // Address decode and control fields
  wire hit_ctrl  = hb_addr == `IOC_OFF_CTRL;
  wire hit_stat  = hb_addr == `IOC_OFF_STATUS;
  wire hit_fifo  = (hb_addr == `IOC_OFF_FIFO) || (hb_addr == `IOC_OFF_FIFO_ALT);
  wire wr_ctrl   = hb_wr && hit_ctrl;
  wire wr_stat   = hb_wr && hit_stat;
  wire lvl       = ctrl_q[`IOC_B_LVLLD];
  wire loop      = ctrl_q[`IOC_B_LOOP];
  wire use_ext   = ctrl_q[`IOC_B_USEEXT];
  wire master    = ctrl_q[`IOC_B_MASTER];
  wire force_int = ctrl_q[`IOC_B_FORCE];
  wire rx_start  = ctrl_q[`IOC_B_RXSTART];
  wire pll_en    = ctrl_q[`IOC_B_PLLEN];
  wire [3:0] en  = ctrl_q[`IOC_B_EN_HI:`IOC_B_EN_LO];
  wire tx_rst    = sys_rst || ctrl_q[`IOC_B_TXRST];
  wire rx_rst    = sys_rst || ctrl_q[`IOC_B_RXRST];
  wire int_rst   = use_ext ? rx_rst : tx_rst;

  // FIFO data paths: level-load diverts, loop-back bypasses the transmit FIFO
  wire host_fw   = hb_wr && hit_fifo;
  wire host_fr   = hb_rd && hit_fifo;
  wire lvl_wr    = host_fw && lvl;
  wire tx_wr     = host_fw && !lvl && !loop && !tx_rst;
  wire loop_wr   = host_fw && !lvl && loop && !rx_rst;
  wire rx_wr     = loop ? loop_wr : (rx_wv_q && !rx_rst);
  wire [31:0] rx_wdata = loop ? hb_wdata : rx_word_q;
  wire tx_rd     = (tx_st_q == ioc_pkg::TX_IDLE) && tx_start_q && !tx_st.empty;
  wire rx_rd     = host_fr && !lvl && !rx_st.empty;

  // Flags of the internal and external FIFOs, mapped onto directions
  wire ioc_pkg::ioc_fifo_st_s int_st = '{empty: cnt_q == '0,
                                         full: cnt_q == (AW+1)'(DEPTH),
                                         aempty: cnt_q <= ae_thr_q,
                                         afull: cnt_q >= af_thr_q};
  wire ioc_pkg::ioc_fifo_st_s ext_st = '{empty: xf_empty, full: xf_full,
                                         aempty: xf_almost_empty, afull: xf_almost_full};
  assign tx_st = sel_st(use_ext, ext_st, int_st);
  assign rx_st = sel_st(!use_ext, ext_st, int_st);
  wire [31:0] tx_rdata = use_ext ? xf_rdata : int_rdata;
  wire [31:0] rx_rdata = use_ext ? int_rdata : xf_rdata;
  wire int_wr = use_ext ? (rx_wr && !rx_st.full) : (tx_wr && !tx_st.full);
  wire int_rd = use_ext ? rx_rd : tx_rd;

  // Status events
  wire done_ev = (tx_st_q == ioc_pkg::TX_IDLE) && tx_start_q && tx_sent_q
                 && tx_st.empty;
  wire ovr_ev  = rx_wv_q && !loop && rx_st.full;
  wire [3:0] lat_set = {rx_st.afull && !rx_rst,
                        tx_st.aempty && !tx_rst,
                        ovr_ev, done_ev};
  wire [3:0] lat_clr = wr_stat ? hb_wdata[`IOC_S_LAT_HI:`IOC_S_LAT_LO] : 4'h0;
  wire [3:0] lat_rst = {rx_rst, tx_rst, rx_rst, tx_rst};
  wire int_act = force_int || |(lat_q & en);
  wire [31:0] status = {16'h0, sd_in_q, 1'b0, int_act, 1'b0, lat_q,
                        !rx_st.empty, rx_st.full, rx_st.afull, rx_st.empty,
                        tx_valid, tx_st.full, tx_st.aempty, tx_st.empty};

  // External FIFO pins follow the direction it serves
  assign xf_wr_en = lvl_wr || (use_ext ? (tx_wr && !tx_st.full) : (rx_wr && !rx_st.full));
  assign xf_wdata = use_ext ? hb_wdata : (lvl_wr ? hb_wdata : rx_wdata);
  assign xf_rd_en = use_ext ? tx_rd : rx_rd;
  assign xf_load  = lvl;
  assign xf_rst   = use_ext ? ctrl_q[`IOC_B_TXRST] : ctrl_q[`IOC_B_RXRST];

  // Control register; transmit start guarded by its enable bit
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      ctrl_q     <= `IOC_CTRL_RESET;
      tx_start_q <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_q <= hb_wdata & `IOC_CTRL_MASK;
      if (wr_ctrl && hb_wdata[`IOC_B_STSTEN])
        tx_start_q <= hb_wdata[`IOC_B_TXSTART];
      else if (done_ev && ctrl_q[`IOC_B_STCLR])
        tx_start_q <= 1'b0;
    end
  end

  // Sticky latches: set wins over write-one clear; FIFO reset clears
  always_ff @(posedge mclk)
  begin
    for (int i = 0; i < 4; i++)
      if (lat_rst[i])
        lat_q[i] <= 1'b0;
      else if (lat_set[i])
        lat_q[i] <= 1'b1;
      else if (lat_clr[i])
        lat_q[i] <= 1'b0;
  end

  // Host interrupt
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      irq_q <= 1'b0;
    else
      irq_q <= master && int_act;
  end
  assign host_irq = irq_q;

  // Internal FIFO pointers, count and threshold load pointer
  always_ff @(posedge mclk)
  begin
    if (int_rst)
    begin
      wp_q      <= '0;
      rp_q      <= '0;
      cnt_q     <= '0;
      lvl_ptr_q <= 1'b0;
    end
    else
    begin
      if (int_wr)
        wp_q <= wp_q + 1'b1;
      if (int_rd)
        rp_q <= rp_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(int_wr) - (AW+1)'(int_rd);
      if (lvl_wr)
        lvl_ptr_q <= !lvl_ptr_q;
    end
  end

  // Thresholds loaded in turn while level-load is set
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      ae_thr_q <= (AW+1)'(`IOC_AE_RESET);
      af_thr_q <= (AW+1)'(`IOC_AF_RESET);
    end
    else if (lvl_wr && !lvl_ptr_q)
      ae_thr_q <= hb_wdata[AW:0];
    else if (lvl_wr)
      af_thr_q <= hb_wdata[AW:0];
  end

  ioc_ram #(.W(32), .AW(AW)) u_ram (
    .mclk    (mclk),
    .wr_en   (int_wr),
    .waddr   (wp_q),
    .wdata   (use_ext ? rx_wdata : hb_wdata),
    .rd_en   (int_rd),
    .raddr   (rp_q),
    .rdata_q (int_rdata)
  );

  // Transmit sequencer: fetch a word, present it, detect running dry
  always_ff @(posedge mclk)
  begin
    if (tx_rst)
    begin
      tx_st_q   <= ioc_pkg::TX_IDLE;
      tx_data_q <= 32'h0;
      tx_sent_q <= 1'b0;
    end
    else
    begin
      unique case (tx_st_q)
        ioc_pkg::TX_IDLE:
        begin
          if (tx_rd)
            tx_st_q <= ioc_pkg::TX_FETCH;
          if (done_ev)
            tx_sent_q <= 1'b0;
        end
        ioc_pkg::TX_FETCH:
        begin
          tx_data_q <= tx_rdata;
          tx_st_q   <= ioc_pkg::TX_SEND;
        end
        ioc_pkg::TX_SEND:
        begin
          if (tx_ready)
          begin
            tx_st_q   <= ioc_pkg::TX_IDLE;
            tx_sent_q <= 1'b1;
          end
        end
      endcase
    end
  end
  assign tx_data  = tx_data_q;
  assign tx_valid = tx_st_q == ioc_pkg::TX_SEND;

  // Receive packer: four bytes, first byte in the low lane
  always_ff @(posedge mclk)
  begin
    if (rx_rst || !rx_start)
    begin
      rx_bcnt_q <= 2'h0;
      rx_sh_q   <= 24'h0;
      rx_wv_q   <= 1'b0;
      rx_word_q <= 32'h0;
    end
    else
    begin
      rx_wv_q <= rx_byte_valid && (rx_bcnt_q == 2'h3);
      if (rx_byte_valid)
      begin
        rx_bcnt_q <= rx_bcnt_q + 2'h1;
        rx_sh_q   <= {rx_byte, rx_sh_q[23:8]};
        if (rx_bcnt_q == 2'h3)
          rx_word_q <= {rx_byte, rx_sh_q};
      end
    end
  end

  // Host read path: select, then registered data two edges after the request
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      rd_sel_q <= 3'h0;
      rdata_q  <= 32'h0;
      rvalid_q <= 1'b0;
    end
    else
    begin
      rd_sel_q <= hb_rd ? {hit_fifo, hit_stat, hit_ctrl} : 3'h0;
      rvalid_q <= |rd_sel_q;
      unique case (1'b1)
        rd_sel_q[0]: rdata_q <= ctrl_q | {18'h0, tx_start_q, 13'h0};
        rd_sel_q[1]: rdata_q <= status;
        rd_sel_q[2]: rdata_q <= lvl ? 32'(lvl_ptr_q ? af_thr_q : ae_thr_q) : rx_rdata;
        default:     rdata_q <= 32'h0;
      endcase
    end
  end
  assign hb_rdata  = rdata_q;
  assign hb_rvalid = rvalid_q;

  // LED blink divider and PLL data input synchroniser
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      led_cnt_q   <= 32'h0;
      led_blink_q <= 1'b0;
      sd_s1_q     <= 1'b1;
      sd_s2_q     <= 1'b1;
      sd_s3_q     <= 1'b1;
      sd_in_q     <= 1'b1;
    end
    else
    begin
      led_cnt_q <= (led_cnt_q == 32'(LED_HALF_CYC - 1)) ? 32'h0 : led_cnt_q + 32'h1;
      if (led_cnt_q == 32'(LED_HALF_CYC - 1))
        led_blink_q <= !led_blink_q;
      sd_s1_q <= pll_sdata_i;
      sd_s2_q <= sd_s1_q;
      sd_s3_q <= sd_s2_q;
      if (sd_s2_q == sd_s3_q)
        sd_in_q <= sd_s3_q;
    end
  end
  assign user_led = ctrl_q[`IOC_B_LEDCTL] ? ctrl_q[`IOC_B_LEDON] : led_blink_q;

  // PLL pins, silent while the PLL enable bit is clear
  assign pll_sclk       = pll_en && ctrl_q[`IOC_B_SCLK];
  assign pll_s2         = pll_en && ctrl_q[`IOC_B_S2];
  assign pll_sdata_o    = 1'b0;
  assign pll_sdata_oe_n = !(pll_en && !ctrl_q[`IOC_B_SDATA]);

  // Checks
  AST_START_GUARD: assert property (@(posedge mclk) disable iff (sys_rst)
    wr_ctrl && !hb_wdata[`IOC_B_STSTEN] && !done_ev |=> $stable(tx_start_q))
    else $error("start bit changed without its enable");
  AST_DONE_CLR: assert property (@(posedge mclk) disable iff (sys_rst)
    done_ev && ctrl_q[`IOC_B_STCLR] && !wr_ctrl |=> !tx_start_q)
    else $error("done did not clear start");
  AST_IRQ: assert property (@(posedge mclk) disable iff (sys_rst)
    (master && |(lat_q & en) |=> host_irq) and (!master |=> !host_irq))
    else $error("interrupt mismatch");
  AST_FORCE: assert property (@(posedge mclk) disable iff (sys_rst)
    wr_ctrl && hb_wdata[`IOC_B_FORCE] && hb_wdata[`IOC_B_MASTER] ##1 !wr_ctrl |=> host_irq)
    else $error("forced interrupt missing");
  AST_LOOP: assert property (@(posedge mclk) disable iff (sys_rst)
    host_fw && loop && !lvl && !rx_rst |-> rx_wr && !tx_wr)
    else $error("loop-back word not moved");
  AST_LVL: assert property (@(posedge mclk) disable iff (sys_rst)
    host_fw && lvl |-> !tx_wr && !rx_wr ##1 (ae_thr_q == $past(hb_wdata[AW:0])
    || af_thr_q == $past(hb_wdata[AW:0])))
    else $error("level-load write reached data");
  AST_TXRST: assert property (@(posedge mclk) disable iff (sys_rst)
    ctrl_q[`IOC_B_TXRST] |=> tx_st_q == ioc_pkg::TX_IDLE && !tx_valid && !lat_q[`IOC_L_DONE])
    else $error("transmit reset incomplete");
  AST_TXOFF: assert property (@(posedge mclk) disable iff (sys_rst)
    !tx_start_q |-> !tx_rd)
    else $error("transmitter read while stopped");
  AST_OVR: assert property (@(posedge mclk) disable iff (sys_rst)
    ovr_ev && !rx_rst |=> lat_q[`IOC_L_OVR])
    else $error("overrun not latched");
  AST_RXPACK: assert property (@(posedge mclk) disable iff (sys_rst)
    rx_start && !rx_rst && rx_byte_valid && rx_bcnt_q == 2'h3
    |=> rx_wv_q && rx_word_q[31:24] == $past(rx_byte) ##1 !rx_wv_q)
    else $error("receive packing wrong");
  AST_PLL: assert property (@(posedge mclk) disable iff (sys_rst)
    !pll_en |-> !pll_sclk && !pll_s2 && pll_sdata_oe_n)
    else $error("PLL pins driven while disabled");
  AST_LED: assert property (@(posedge mclk) disable iff (sys_rst)
    ctrl_q[`IOC_B_LEDCTL] |-> user_led == ctrl_q[`IOC_B_LEDON])
    else $error("LED not under control bit");

endmodule

`default_nettype wire

// ### testbench/ioc_xfifo_model.sv
`timescale 1ns/1ps
`default_nettype none

// Behavioural stand-in for the external word FIFO, same clock domain
module ioc_xfifo_model #(
  parameter int DEPTH = 16
) (
  // Clock and control
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        load,
  // Write side
  input  wire logic        wr_en,
  input  wire logic [31:0] wdata,
  // Read side
  input  wire logic        rd_en,
  output logic      [31:0] rdata,
  // Flags
  output logic             empty,
  output logic             full,
  output logic             aempty,
  output logic             afull
);
  logic [31:0] mem [DEPTH];
  int          wp;
  int          rp;
  int          cnt;

  // Level flags from the word count
  assign empty  = (cnt == 0);
  assign full   = (cnt == DEPTH);
  assign aempty = (cnt <= 2);
  assign afull  = (cnt >= DEPTH - 2);

  // Storage; a read of an empty FIFO gives the inverted last word, never a copy
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      wp <= 0;
      rp <= 0;
      cnt <= 0;
    end
    else
    begin
      if (wr_en && !full && !load)
      begin
        mem[wp] <= wdata;
        wp <= (wp + 1) % DEPTH;
      end
      if (rd_en)
        rdata <= empty ? ~rdata : mem[rp];
      if (rd_en && !empty)
        rp <= (rp + 1) % DEPTH;
      cnt <= cnt + int'(wr_en && !full && !load) - int'(rd_en && !empty);
    end
  end
endmodule

`default_nettype wire

// ### testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic        mclk, sys_rst, hb_wr, hb_rd, hb_rvalid, host_irq, got;
  logic [7:0]  hb_addr, rx_byte;
  logic [31:0] hb_wdata, hb_rdata, xf_wdata, xf_rdata, tx_data, rdv;
  logic        xf_wr_en, xf_rd_en, xf_empty, xf_full, xf_ae, xf_af, xf_load, xf_rst;
  logic        tx_valid, tx_ready, rx_byte_valid, user_led, pll_sclk, pll_s2;
  logic        pll_sdata_o, pll_sdata_oe_n, led0;
  wire  logic  pll_sdata_i;
  int          num_errors, n_compared, i;

  // Open-drain data line with pull-up
  assign pll_sdata_i = pll_sdata_oe_n ? 1'b1 : pll_sdata_o;

  ioc_base_control #(.AW(4), .LED_HALF_CYC(8)) DUT (
    .mclk(mclk), .sys_rst(sys_rst), .hb_addr(hb_addr), .hb_wr(hb_wr), .hb_rd(hb_rd),
    .hb_wdata(hb_wdata), .hb_rdata(hb_rdata), .hb_rvalid(hb_rvalid), .host_irq(host_irq),
    .xf_wr_en(xf_wr_en), .xf_wdata(xf_wdata), .xf_rd_en(xf_rd_en), .xf_rdata(xf_rdata),
    .xf_empty(xf_empty), .xf_full(xf_full), .xf_almost_empty(xf_ae),
    .xf_almost_full(xf_af), .xf_load(xf_load), .xf_rst(xf_rst), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_byte(rx_byte),
    .rx_byte_valid(rx_byte_valid), .user_led(user_led), .pll_sclk(pll_sclk),
    .pll_s2(pll_s2), .pll_sdata_o(pll_sdata_o), .pll_sdata_oe_n(pll_sdata_oe_n),
    .pll_sdata_i(pll_sdata_i));

  ioc_xfifo_model xfm (
    .mclk(mclk), .rst(xf_rst), .load(xf_load), .wr_en(xf_wr_en), .wdata(xf_wdata),
    .rd_en(xf_rd_en), .rdata(xf_rdata), .empty(xf_empty), .full(xf_full),
    .aempty(xf_ae), .afull(xf_af));

  // Clock
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // Step whole cycles, landing just after the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e)
    begin
      num_errors++;
      $display("mismatch at %0t: word %h, expected %h", $time, g, e);
    end
  endtask

  task automatic chk_bit(input logic g, input logic e);
    n_compared++;
    if (g !== e)
    begin
      num_errors++;
      $display("mismatch at %0t: flag %b, expected %b", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    hb_addr = a;
    hb_wdata = d;
    hb_wr = 1'b1;
    cyc(1);
    hb_wr = 1'b0;
    cyc(1);
  endtask

  // Read strobe, then wait a bounded time for the answer marker
  task automatic rd(input logic [7:0] a);
    hb_addr = a;
    hb_rd = 1'b1;
    cyc(1);
    hb_rd = 1'b0;
    got = 1'b0;
    for (int k = 0; k < 4 && !got; k++)
    begin
      cyc(1);
      if (hb_rvalid === 1'b1)
      begin
        got = 1'b1;
        rdv = hb_rdata;
      end
    end
  endtask

  task automatic rdm(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    rd(a);
    chk_bit(got, 1'b1);
    chk(rdv & m, e);
  endtask

  task automatic send_byte(input logic [7:0] b);
    rx_byte = b;
    rx_byte_valid = 1'b1;
    cyc(1);
    rx_byte_valid = 1'b0;
    rx_byte = ~b;
    cyc(1);
  endtask

  task automatic conclude;
    $display("comparisons %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Watchdog well beyond the expected run
  initial
  begin
    #300000;
    num_errors++;
    $display("mismatch at %0t: run did not finish", $time);
    conclude;
  end

  // Test sequence
  initial
  begin
    {hb_wr, hb_rd, rx_byte_valid} = '0;
    {hb_addr, rx_byte, hb_wdata} = '0;
    tx_ready = 1'b1;
    sys_rst = 1'b1;
    cyc(20);
    sys_rst = 1'b0;
    rdm(8'h00, 32'h0, 32'hffff_ffff);
    chk_bit(host_irq, 1'b0);
    rdm(8'h04, 32'h402, 32'h402);
    wr(8'h00, 32'h410);
    cyc(3);
    chk_bit(host_irq, 1'b1);
    wr(8'h00, 32'h400);
    cyc(3);
    chk_bit(host_irq, 1'b0);
    wr(8'h00, 32'h20);
    cyc(3);
    chk_bit(host_irq, 1'b0);
    wr(8'h00, 32'h30);
    cyc(3);
    chk_bit(host_irq, 1'b1);
    // Start bit only moves with its enable
    wr(8'h00, 32'h2000);
    rdm(8'h00, 32'h0, 32'hffff_ffff);
    wr(8'h00, 32'h6000);
    rdm(8'h00, 32'h2000, 32'hffff_ffff);
    wr(8'h00, 32'h4000);
    rdm(8'h00, 32'h0, 32'hffff_ffff);
    // LED and PLL pins
    wr(8'h00, 32'h1_8000);
    cyc(2);
    chk_bit(user_led, 1'b1);
    wr(8'h00, 32'h8000);
    cyc(2);
    chk_bit(user_led, 1'b0);
    wr(8'h00, 32'h0);
    led0 = user_led;
    cyc(8);
    chk_bit(user_led, !led0);
    wr(8'h00, 32'hb0_0000);
    cyc(2);
    chk({pll_sclk, pll_s2, pll_sdata_oe_n}, 32'h6);
    rdm(8'h04, 32'h0, 32'h8000);
    wr(8'h00, 32'hf0_0000);
    cyc(2);
    rdm(8'h04, 32'h8000, 32'h8000);
    wr(8'h00, 32'h70_0000);
    cyc(2);
    chk({pll_sclk, pll_s2, pll_sdata_oe_n}, 32'h1);
    wr(8'h00, 32'h44);
    cyc(1);
    chk_bit(xf_load, 1'b1);
    wr(8'h0c, 32'h3);
    wr(8'h0c, 32'hc);
    rdm(8'h0c, 32'h3, 32'hffff_ffff);
    // Transmit through the external FIFO, auto-clear of start on done
    wr(8'h00, 32'h1d0);
    wr(8'h0c, 32'ha5a5_0001);
    tx_ready = 1'b0;
    wr(8'h00, 32'h61d0);
    for (i = 0; i < 20 && tx_valid !== 1'b1; i++)
      cyc(1);
    chk(tx_data, 32'ha5a5_0001);
    cyc(2);
    chk_bit(tx_valid, 1'b1);
    tx_ready = 1'b1;
    cyc(12);
    rdm(8'h00, 32'h1d0, 32'hffff_ffff);
    chk_bit(host_irq, 1'b1);
    rdm(8'h04, 32'h100, 32'h100);
    wr(8'h04, 32'hf00);
    // Receive packing into the internal FIFO
    wr(8'h00, 32'h1040);
    for (i = 1; i <= 4; i++)
      send_byte(8'(i * 8'h11));
    cyc(4);
    rdm(8'h0c, 32'h4433_2211, 32'hffff_ffff);
    // Overrun of the full receive FIFO
    wr(8'h00, 32'h1250);
    for (i = 0; i < 72; i++)
      send_byte(8'(i));
    cyc(4);
    rdm(8'h04, 32'ha40, 32'ha40);
    chk_bit(host_irq, 1'b1);
    // Receive reset held four cycles
    wr(8'h00, 32'h42);
    cyc(2);
    wr(8'h00, 32'h40);
    wr(8'h04, 32'hf00);
    rdm(8'h04, 32'h0, 32'hac0);
    // Loop-back of host words
    wr(8'h00, 32'h48);
    wr(8'h0c, 32'h1234_5678);
    cyc(4);
    rdm(8'h40, 32'h1234_5678, 32'hffff_ffff);
    // Unmapped place
    rd(8'h80);
    chk_bit(got, 1'b0);
    wr(8'h80, 32'hffff_ffff);
    rdm(8'h00, 32'h48, 32'hffff_ffff);
    conclude;
  end
endmodule

`default_nettype wire
